// *** lhcs_defines.svh ***
// Timing constants and watchdog failure thresholds for the limp-home and configuration-select block
`ifndef LHCS_DEFINES_SVH
`define LHCS_DEFINES_SVH
`define LHCS_CLK_HZ 200000000
`define LHCS_UV_TIMEOUT_MS 1024
`define LHCS_UV_TIMEOUT_CYC ((`LHCS_CLK_HZ / 1000) * `LHCS_UV_TIMEOUT_MS)
`define LHCS_IND_RATE_CHZ 125
`define LHCS_IND_HALF_CYC ((`LHCS_CLK_HZ / 2) / `LHCS_IND_RATE_CHZ * 100)
`define LHCS_LIGHT_RATE_HZ 100
`define LHCS_LIGHT_DUTY_PCT 20
`define LHCS_LIGHT_PER_CYC (`LHCS_CLK_HZ / `LHCS_LIGHT_RATE_HZ)
`define LHCS_LIGHT_LOW_CYC (`LHCS_LIGHT_PER_CYC * `LHCS_LIGHT_DUTY_PCT / 100)
`define LHCS_WD_FAIL_DEF 2'h2
`define LHCS_WD_FAIL_OPT 2'h1
`endif

// *** lhcs_pkg.sv ***
// Types for the limp-home and configuration-select block
package lhcs_pkg;
    typedef enum logic [2:0] {
        LHCS_MODE_INIT,
        LHCS_MODE_NORMAL,
        LHCS_MODE_STOP,
        LHCS_MODE_SLEEP,
        LHCS_MODE_RESTART,
        LHCS_MODE_FAILSAFE,
        LHCS_MODE_FLASH
    } lhcs_mode_e;
    typedef enum logic [1:0] {
        LHCS_REL_IDLE,
        LHCS_REL_RESTARTED,
        LHCS_REL_TRIGGERED
    } lhcs_rel_e;
endpackage

// *** lhcs_pulse_gen.sv ***
// Free-running pulse generator: low phase then high phase, restarted while idle
`timescale 1ns/1ps
module lhcs_pulse_gen #(
    parameter int unsigned PERIOD = 2,
    parameter int unsigned LOW_CYC = 1
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Control
    input wire logic run_i,
    // Output, high while the low phase is active
    output logic low_phase_o
);
    localparam int unsigned CW = $clog2(PERIOD);
    logic [CW-1:0] cnt_r;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || !run_i) begin
            cnt_r <= '0;
        end else if (cnt_r == CW'(PERIOD - 1)) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            low_phase_o <= 1'b0;
        end else begin
            low_phase_o <= run_i && (cnt_r < CW'(LOW_CYC));
        end
    end
endmodule

// *** lhcs_top.sv ***
// Limp-home supervisor with once-only configuration select
`timescale 1ns/1ps
`include "lhcs_defines.svh"

module lhcs_top #(
    parameter int unsigned UV_TIMEOUT_CYC = `LHCS_UV_TIMEOUT_CYC,
    parameter int unsigned IND_HALF_CYC = `LHCS_IND_HALF_CYC,
    parameter int unsigned LIGHT_PER_CYC = `LHCS_LIGHT_PER_CYC,
    parameter int unsigned LIGHT_LOW_CYC = `LHCS_LIGHT_LOW_CYC
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Mode state from the chip state machine
    input wire lhcs_pkg::lhcs_mode_e mode_i,
    input wire logic restart_entry_i,
    // Host commands over SPI, one-cycle pulses, and the held one-failure threshold select
    input wire logic spi_lh_on_i,
    input wire logic spi_lh_off_i,
    input wire logic wd_trigger_ok_i,
    input wire logic wd_fail_i,
    input wire logic wd_fail_one_sel_i,
    // Failure causes
    input wire logic reset_clamp_i,
    input wire logic init_timeout_i,
    input wire logic other_fail_i,
    // Analog comparators and configuration pin, asynchronous
    input wire logic mcu_supply_low_i,
    input wire logic battery_uv_gate_ok_i,
    input wire logic limp_battery_ok_i,
    input wire logic supply_above_default_i,
    input wire logic cfg_pin_i,
    // Reset pin state from the reset block
    input wire logic reset_out_pin_i,
    // Limp-home outputs, enable high means pin driven low
    output logic limp_out_oe_o,
    output logic side_indicator_out_oe_o,
    output logic pulsed_light_out_oe_o,
    // Supervisor results
    output logic supply_uv_timeout_o,
    output logic failsafe_req_o,
    output logic mcu_supply_off_o,
    output logic limp_active_o,
    // Configuration pin control
    output logic cfg_pulldown_en_o,
    output logic int_pullup_en_o,
    output logic cfg_keep_supply_o
);
    localparam int unsigned UVW = $clog2(UV_TIMEOUT_CYC + 1);
    localparam int unsigned INW = $clog2(IND_HALF_CYC);

    // Two-stage synchronisers for comparator and pin inputs
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
        end else begin
            sync1_r <= {cfg_pin_i, supply_above_default_i, limp_battery_ok_i,
                        battery_uv_gate_ok_i, mcu_supply_low_i};
            sync2_r <= sync1_r;
        end
    end
    logic sup_low, bat_gate, bat_limp, sup_dflt, cfg_pin;
    assign sup_low = sync2_r[0];
    assign bat_gate = sync2_r[1];
    assign bat_limp = sync2_r[2];
    assign sup_dflt = sync2_r[3];
    assign cfg_pin = sync2_r[4];

    logic in_init;
    assign in_init = (mode_i == lhcs_pkg::LHCS_MODE_INIT);

    // Undervoltage time-out counter
    logic [UVW-1:0] uv_cnt_r;
    logic uv_to_r;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || !(sup_low && bat_gate)) begin
            uv_cnt_r <= '0;
            uv_to_r <= 1'b0;
        end else if (uv_cnt_r < UVW'(UV_TIMEOUT_CYC)) begin
            uv_cnt_r <= uv_cnt_r + 1'b1;
            uv_to_r <= 1'b0;
        end else begin
            uv_to_r <= 1'b1;
        end
    end
    assign supply_uv_timeout_o = uv_to_r;

    // Configuration capture, once in Init before reset output rises
    logic cfg_done_r, cfg_keep_r;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            cfg_done_r <= 1'b0;
            cfg_keep_r <= 1'b0;
        end else if (!cfg_done_r && in_init) begin
            if (reset_out_pin_i) begin
                cfg_done_r <= 1'b1;
            end else if (sup_dflt) begin
                cfg_keep_r <= cfg_pin;
            end
        end
    end
    assign cfg_pulldown_en_o = !cfg_done_r;
    assign int_pullup_en_o = cfg_done_r;
    assign cfg_keep_supply_o = cfg_keep_r;

    // Watchdog failure counting against the threshold
    logic [1:0] wd_cnt_r;
    logic [1:0] wd_thr;
    logic wd_hit;
    assign wd_thr = wd_fail_one_sel_i ? `LHCS_WD_FAIL_OPT : `LHCS_WD_FAIL_DEF;
    // Widened so a saturated count of 3 still reaches the threshold
    assign wd_hit = wd_fail_i && (({1'b0, wd_cnt_r} + 3'h1) >= {1'b0, wd_thr});
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || wd_trigger_ok_i) begin
            wd_cnt_r <= 2'h0;
        end else if (wd_fail_i && wd_cnt_r != 2'h3) begin
            wd_cnt_r <= wd_cnt_r + 2'h1;
        end
    end

    // Fail-Safe request and supply switch-off
    logic fs_r, off_r;
    logic fail_ev;
    assign fail_ev = wd_hit || reset_clamp_i;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            fs_r <= 1'b0;
            off_r <= 1'b0;
        end else begin
            // A new failure wins over a restart in the same cycle
            if (uv_to_r || (fail_ev && !cfg_keep_r)) begin
                fs_r <= 1'b1;
            end else if (restart_entry_i) begin
                fs_r <= 1'b0;
            end
            if (fail_ev && !cfg_keep_r) begin
                off_r <= 1'b1;
            end else if (restart_entry_i) begin
                off_r <= 1'b0;
            end
        end
    end
    assign failsafe_req_o = fs_r;
    assign mcu_supply_off_o = off_r;

    // Limp-home activation and release sequence
    logic lh_r, by_spi_r;
    lhcs_pkg::lhcs_rel_e rel_r;
    logic auto_ev;
    assign auto_ev = uv_to_r || wd_hit || reset_clamp_i || init_timeout_i || other_fail_i;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            lh_r <= 1'b0;
            by_spi_r <= 1'b0;
            rel_r <= lhcs_pkg::LHCS_REL_IDLE;
        end else if (auto_ev && bat_limp) begin
            lh_r <= 1'b1;
            by_spi_r <= 1'b0;
            rel_r <= lhcs_pkg::LHCS_REL_IDLE;
        end else if (spi_lh_on_i && bat_limp && !lh_r
                     && mode_i == lhcs_pkg::LHCS_MODE_NORMAL) begin
            lh_r <= 1'b1;
            by_spi_r <= 1'b1;
        end else if (lh_r && by_spi_r) begin
            if (spi_lh_off_i) begin
                lh_r <= 1'b0;
            end
        end else if (lh_r) begin
            unique case (rel_r)
                lhcs_pkg::LHCS_REL_IDLE: begin
                    if (restart_entry_i) begin
                        rel_r <= lhcs_pkg::LHCS_REL_RESTARTED;
                    end
                end
                lhcs_pkg::LHCS_REL_RESTARTED: begin
                    if (wd_trigger_ok_i && mode_i == lhcs_pkg::LHCS_MODE_NORMAL) begin
                        rel_r <= lhcs_pkg::LHCS_REL_TRIGGERED;
                    end
                end
                lhcs_pkg::LHCS_REL_TRIGGERED: begin
                    if (spi_lh_off_i && mode_i == lhcs_pkg::LHCS_MODE_NORMAL) begin
                        lh_r <= 1'b0;
                        rel_r <= lhcs_pkg::LHCS_REL_IDLE;
                    end
                end
                default: rel_r <= lhcs_pkg::LHCS_REL_IDLE;
            endcase
        end
    end

    logic lh_on;
    assign lh_on = lh_r && bat_limp;
    assign limp_active_o = lh_on;

    // Side indicator: half-period divider toggles the phase
    logic [INW-1:0] ind_cnt_r;
    logic ind_ph_r;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || !lh_on) begin
            ind_cnt_r <= '0;
            ind_ph_r <= 1'b0;
        end else if (ind_cnt_r == INW'(IND_HALF_CYC - 1)) begin
            ind_cnt_r <= '0;
            ind_ph_r <= !ind_ph_r;
        end else begin
            ind_cnt_r <= ind_cnt_r + 1'b1;
        end
    end

    logic pl_low;
    lhcs_pulse_gen #(
        .PERIOD(LIGHT_PER_CYC),
        .LOW_CYC(LIGHT_LOW_CYC)
    ) u_light (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .run_i(lh_on && !in_init),
        .low_phase_o(pl_low)
    );

    // Registered output enables
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            limp_out_oe_o <= 1'b0;
            side_indicator_out_oe_o <= 1'b0;
            pulsed_light_out_oe_o <= 1'b0;
        end else begin
            limp_out_oe_o <= lh_on;
            side_indicator_out_oe_o <= lh_on && !ind_ph_r;
            pulsed_light_out_oe_o <= lh_on && !in_init && pl_low;
        end
    end
endmodule

// *** lhcs_chk_sva.sv ***
// Port assertions for the limp-home supervisor
`timescale 1ns/1ps
module lhcs_chk (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Watched ports
    input wire lhcs_pkg::lhcs_mode_e mode_i,
    input wire logic reset_out_pin_i,
    input wire logic limp_out_oe_o,
    input wire logic side_indicator_out_oe_o,
    input wire logic pulsed_light_out_oe_o,
    input wire logic limp_active_o,
    input wire logic mcu_supply_off_o,
    input wire logic cfg_pulldown_en_o,
    input wire logic int_pullup_en_o,
    input wire logic cfg_keep_supply_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_frz; !cfg_pulldown_en_o |=> $stable(cfg_keep_supply_o); endproperty
    a_frz: assert property (p_frz) else $error("config moved");
    property p_pd; int_pullup_en_o != cfg_pulldown_en_o; endproperty
    a_pd: assert property (p_pd) else $error("pull clash");
    property p_pu; mode_i == lhcs_pkg::LHCS_MODE_INIT && reset_out_pin_i |=> int_pullup_en_o; endproperty
    a_pu: assert property (p_pu) else $error("pull-up late");
    property p_pur; $rose(int_pullup_en_o) |-> $past(reset_out_pin_i) && $past(mode_i) == lhcs_pkg::LHCS_MODE_INIT; endproperty
    a_pur: assert property (p_pur) else $error("pull-up early");
    property p_bat; $fell(limp_active_o) |=> !limp_out_oe_o && !side_indicator_out_oe_o; endproperty
    a_bat: assert property (p_bat) else $error("limp kept");
    property p_ini; $stable(mode_i) && mode_i == lhcs_pkg::LHCS_MODE_INIT |-> !pulsed_light_out_oe_o; endproperty
    a_ini: assert property (p_ini) else $error("light in init");
    property p_pl; $rose(pulsed_light_out_oe_o) |=> (pulsed_light_out_oe_o || !limp_out_oe_o) ##1 !pulsed_light_out_oe_o; endproperty
    a_pl: assert property (p_pl) else $error("light width");
    property p_si; $changed(side_indicator_out_oe_o) && limp_out_oe_o |=> ($stable(side_indicator_out_oe_o) || !limp_out_oe_o)[*7]; endproperty
    a_si: assert property (p_si) else $error("indicator half");
    property p_keep; cfg_keep_supply_o |-> !mcu_supply_off_o; endproperty
    a_keep: assert property (p_keep) else $error("supply off");
endmodule

// *** lhcs_host.sv ***
// Host model issuing SPI limp commands and watchdog events
`timescale 1ns/1ps
module lhcs_host (
    // Clock
    input wire logic sys_clk_i,
    // One-cycle command pulses
    output logic spi_lh_on_o,
    output logic spi_lh_off_o,
    output logic wd_trigger_ok_o,
    output logic wd_fail_o
);
    initial begin
        {spi_lh_on_o, spi_lh_off_o, wd_trigger_ok_o, wd_fail_o} = 4'h0;
    end
    // Code 0 limp on, 1 limp off, 2 good trigger, 3 watchdog failure
    task automatic send(input int k);
        @(posedge sys_clk_i);
        {spi_lh_on_o, spi_lh_off_o, wd_trigger_ok_o, wd_fail_o} <= 4'h8 >> k;
        @(posedge sys_clk_i);
        {spi_lh_on_o, spi_lh_off_o, wd_trigger_ok_o, wd_fail_o} <= 4'h0;
    endtask
endmodule

// *** test_lhcs_top.sv ***
// Testbench for the limp-home supervisor
`timescale 1ns/1ps
module test_lhcs_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    lhcs_pkg::lhcs_mode_e mode = lhcs_pkg::LHCS_MODE_INIT;
    logic rse = 1'b0, sel = 1'b0, low = 1'b0, gate = 1'b0, bat = 1'b1, pin = 1'b0, ro = 1'b0;
    logic clamp = 1'b0, ito = 1'b0, ofl = 1'b0, sdef = 1'b1;
    logic on, off, trg, fail, lo, si, pl, uv, fs, soff, la, pd, pu, keep;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;
    lhcs_host i_host (.sys_clk_i(clk), .spi_lh_on_o(on), .spi_lh_off_o(off), .wd_trigger_ok_o(trg), .wd_fail_o(fail));
    lhcs_top #(.UV_TIMEOUT_CYC(50), .IND_HALF_CYC(8), .LIGHT_PER_CYC(10), .LIGHT_LOW_CYC(2)) i_dut (
        .sys_clk_i(clk), .rst_b_i(rst_b), .mode_i(mode), .restart_entry_i(rse), .spi_lh_on_i(on),
        .spi_lh_off_i(off), .wd_trigger_ok_i(trg), .wd_fail_i(fail), .wd_fail_one_sel_i(sel),
        .reset_clamp_i(clamp), .init_timeout_i(ito), .other_fail_i(ofl), .mcu_supply_low_i(low),
        .battery_uv_gate_ok_i(gate), .limp_battery_ok_i(bat), .supply_above_default_i(sdef), .cfg_pin_i(pin),
        .reset_out_pin_i(ro), .limp_out_oe_o(lo), .side_indicator_out_oe_o(si), .pulsed_light_out_oe_o(pl),
        .supply_uv_timeout_o(uv), .failsafe_req_o(fs), .mcu_supply_off_o(soff), .limp_active_o(la),
        .cfg_pulldown_en_o(pd), .int_pullup_en_o(pu), .cfg_keep_supply_o(keep));
    task automatic chk(input logic e, input logic a);
        cmp_count++;
        if (a !== e) begin
            miscompares++;
            $display("Error %0t exp %h got %h", $time, e, a);
        end
    endtask
    task automatic chk_n(input logic [7:0] e, input logic [7:0] a);
        cmp_count++;
        if (a !== e) begin
            miscompares++;
            $display("Error %0t exp %h got %h", $time, e, a);
        end
    endtask
    task automatic complete_run();
        $display("mismatches %0d of %0d compares", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic fire(input int k, input logic e);
        i_host.send(k);
        wt(4);
        chk(e, lo);
    endtask
    task automatic t_cfg(input logic p);
        @(posedge clk);
        rst_b <= 1'b0;
        mode <= lhcs_pkg::LHCS_MODE_INIT;
        ro <= 1'b0;
        pin <= p;
        sdef <= 1'b0;
        wt(16);
        @(posedge clk);
        rst_b <= 1'b1;
        wt(6);
        chk(1'b0, keep);
        @(posedge clk);
        sdef <= 1'b1;
        wt(6);
        chk(p, keep);
        chk(1'b1, pd);
        chk(1'b0, pu);
        @(posedge clk);
        ro <= 1'b1;
        @(posedge clk);
        pin <= ~p;
        wt(6);
        chk(p, keep);
        chk(1'b1, pu);
        @(posedge clk);
        mode <= lhcs_pkg::LHCS_MODE_NORMAL;
    endtask
    task automatic t_rel();
        fire(1, 1'b1);
        @(posedge clk);
        rse <= 1'b1;
        @(posedge clk);
        rse <= 1'b0;
        fire(2, 1'b1);
        fire(1, 1'b0);
    endtask
    task automatic t_ito();
        logic [7:0] n_pl;
        logic [7:0] n_si;
        n_pl = 8'h00;
        n_si = 8'h00;
        @(posedge clk);
        mode <= lhcs_pkg::LHCS_MODE_INIT;
        fire(0, 1'b0);
        @(posedge clk);
        ito <= 1'b1;
        @(posedge clk);
        ito <= 1'b0;
        repeat (12) begin
            wt(1);
            n_pl = n_pl + {7'h00, pl};
        end
        chk(1'b1, lo);
        chk_n(8'h00, n_pl);
        @(posedge clk);
        mode <= lhcs_pkg::LHCS_MODE_NORMAL;
        wt(12);
        n_pl = 8'h00;
        repeat (10) begin
            wt(1);
            n_pl = n_pl + {7'h00, pl};
        end
        chk_n(8'h02, n_pl);
        repeat (16) begin
            wt(1);
            n_si = n_si + {7'h00, si};
        end
        chk_n(8'h08, n_si);
        t_rel();
    endtask
    task automatic t_cause(input logic k);
        @(posedge clk);
        clamp <= k;
        ofl <= !k;
        @(posedge clk);
        clamp <= 1'b0;
        ofl <= 1'b0;
        wt(4);
        chk(1'b1, lo);
        chk(1'b0, soff);
        chk(1'b0, fs);
        t_rel();
    endtask
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        t_cfg(1'b0);
        @(posedge clk);
        sel <= 1'b1;
        fire(3, 1'b1);
        chk(1'b1, soff);
        chk(1'b1, fs);
        t_cfg(1'b1);
        fire(3, 1'b1);
        chk(1'b0, soff);
        wt(40);
        t_rel();
        @(posedge clk);
        sel <= 1'b0;
        fire(3, 1'b0);
        fire(3, 1'b1);
        t_rel();
        fire(0, 1'b1);
        fire(1, 1'b0);
        @(posedge clk);
        low <= 1'b1;
        gate <= 1'b1;
        wt(40);
        chk(1'b0, uv);
        @(posedge clk);
        low <= 1'b0;
        wt(4);
        @(posedge clk);
        low <= 1'b1;
        wt(45);
        chk(1'b0, uv);
        wt(15);
        chk(1'b1, uv);
        chk(1'b1, lo);
        chk(1'b1, fs);
        @(posedge clk);
        bat <= 1'b0;
        wt(6);
        chk(1'b0, lo);
        @(posedge clk);
        low <= 1'b0;
        bat <= 1'b1;
        wt(6);
        chk(1'b1, lo);
        t_rel();
        t_ito();
        t_cause(1'b1);
        t_cause(1'b0);
        complete_run();
    end
endmodule
bind lhcs_top lhcs_chk i_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .mode_i(mode_i),
    .reset_out_pin_i(reset_out_pin_i), .limp_out_oe_o(limp_out_oe_o),
    .side_indicator_out_oe_o(side_indicator_out_oe_o), .pulsed_light_out_oe_o(pulsed_light_out_oe_o),
    .limp_active_o(limp_active_o), .mcu_supply_off_o(mcu_supply_off_o), .cfg_pulldown_en_o(cfg_pulldown_en_o),
    .int_pullup_en_o(int_pullup_en_o), .cfg_keep_supply_o(cfg_keep_supply_o));
